// File: iod_cfg.svh
// register offsets, field masks, reset values and address limits of the low i/o space
`ifndef IOD_CFG_SVH
`define IOD_CFG_SVH

// ----------------------------------------------------------------
// address limits: bit and port tops in i/o numbering, extended base in data-space numbering
// ----------------------------------------------------------------
`define IOD_BIT_TOP      8'h1F
`define IOD_PORT_TOP     8'h3F
`define IOD_DATA_OFFSET  8'h20
`define IOD_EXT_BASE     8'h60

// ----------------------------------------------------------------
// i/o register offsets
// ----------------------------------------------------------------
`define IOD_ADDR_PORT_A_INPUT_LEVELS    6'h00
`define IOD_ADDR_PORT_A_DIRECTION    6'h01
`define IOD_ADDR_PORT_A_OUTPUT_LATCH   6'h02
`define IOD_ADDR_PORT_C_INPUT_LEVELS    6'h06
`define IOD_ADDR_PORT_C_DIRECTION    6'h07
`define IOD_ADDR_PORT_C_OUTPUT_LATCH   6'h08
`define IOD_ADDR_PORT_D_INPUT_LEVELS    6'h09
`define IOD_ADDR_PORT_D_DIRECTION    6'h0A
`define IOD_ADDR_PORT_D_OUTPUT_LATCH   6'h0B
`define IOD_ADDR_PORT_E_INPUT_LEVELS    6'h0C
`define IOD_ADDR_PORT_E_DIRECTION    6'h0D
`define IOD_ADDR_PORT_E_OUTPUT_LATCH   6'h0E
`define IOD_ADDR_TFLG0   6'h15
`define IOD_ADDR_TFLG1   6'h16
`define IOD_ADDR_PCFLG   6'h1B
`define IOD_ADDR_EIFLG   6'h1C
`define IOD_ADDR_EIMASK  6'h1D
`define IOD_ADDR_SCR0    6'h1E
`define IOD_ADDR_PRESC   6'h23
`define IOD_ADDR_T0CA    6'h24
`define IOD_ADDR_T0CB    6'h25
`define IOD_ADDR_T0CNT   6'h26
`define IOD_ADDR_T0CMP   6'h27
`define IOD_ADDR_SCR1    6'h2A
`define IOD_ADDR_SCR2    6'h2B
`define IOD_ADDR_DBGCH   6'h31
`define IOD_ADDR_SLEEP   6'h33
`define IOD_ADDR_RSTC    6'h34
`define IOD_ADDR_SPROG   6'h37
`define IOD_ADDR_STKL    6'h3D
`define IOD_ADDR_STKH    6'h3E
`define IOD_ADDR_CPUST   6'h3F

// ----------------------------------------------------------------
// implemented-bit masks
// ----------------------------------------------------------------
`define IOD_MASK_FULL    8'hFF
`define IOD_MASK_PORT_C_OUTPUT_LATCH   8'h3F
`define IOD_MASK_TFLG    8'h03
`define IOD_MASK_NIB     8'h0F
`define IOD_MASK_PRESC   8'h83
`define IOD_MASK_T0CA    8'hC3
`define IOD_MASK_RSTC    8'h1F
`define IOD_MASK_NONE    8'h00

// ----------------------------------------------------------------
// reset value
// ----------------------------------------------------------------
`define IOD_RESET_VALUE  8'h00

`endif

// File: iod_pkg.sv
// types shared by the i/o space decoder
package iod_pkg;

    typedef enum logic [2:0] {
        REQ_PORT_IN    = 3'b000,
        REQ_PORT_OUT   = 3'b001,
        REQ_BIT_SET    = 3'b010,
        REQ_BIT_CLEAR  = 3'b011,
        REQ_SKIP_SET   = 3'b100,
        REQ_SKIP_CLEAR = 3'b101,
        REQ_DATA_LOAD  = 3'b110,
        REQ_DATA_STORE = 3'b111
    } req_kind_type;

endpackage

// File: io_space_access_decoder.sv
// decoder and register bank of the core-visible low i/o space
//
// Summary of operation
// - bit set/clear reach only i/o 0x00-0x1F
// - skip-if-bit tests one bit in low range
// - flagged status bits clear on written one
// - bit set/clear rewrite whole register, clearing flags
// - data-space address equals i/o address plus 0x20
`timescale 1ns/1ns
`include "iod_cfg.svh"

module io_space_access_decoder (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    input  wire logic                req_valid_i,
    input  wire iod_pkg::req_kind_type req_kind_i,
    input  wire logic [7:0]          addr_i,
    input  wire logic [2:0]          bit_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic [7:0]          port_a_pins_i,
    input  wire logic [7:0]          port_c_pins_i,
    input  wire logic [7:0]          port_d_pins_i,
    input  wire logic [7:0]          port_e_pins_i,
    input  wire logic [1:0]          timer0_flag_set_i,
    input  wire logic [1:0]          timer1_flag_set_i,
    input  wire logic [3:0]          pin_change_flag_set_i,
    input  wire logic [3:0]          ext_irq_flag_set_i,
    output logic                     ack_o,
    output logic [7:0]               rdata_o,
    output logic                     skip_o,
    output logic                     refused_o,
    output logic                     ext_valid_o,
    output logic                     ext_write_o,
    output logic [7:0]               ext_addr_o,
    output logic [7:0]               ext_wdata_o,
    output logic [7:0]               port_a_dir_o,
    output logic [7:0]               port_a_out_o,
    output logic [7:0]               port_c_dir_o,
    output logic [7:0]               port_c_out_o,
    output logic [7:0]               port_d_dir_o,
    output logic [7:0]               port_d_out_o,
    output logic [7:0]               port_e_dir_o,
    output logic [7:0]               port_e_out_o
);
    import iod_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [63:0][7:0] regs;
        logic             ack;
        logic [7:0]       rdata;
        logic             skip;
        logic             refused;
        logic             ext_valid;
        logic             ext_write;
        logic [7:0]       ext_addr;
        logic [7:0]       ext_wdata;
    } state_type;

    state_type state_q;
    state_type state_d;

    // ----------------------------------------------------------------
    // per-address attributes
    // ----------------------------------------------------------------
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        case (a)
            `IOD_ADDR_PORT_A_INPUT_LEVELS, `IOD_ADDR_PORT_A_DIRECTION, `IOD_ADDR_PORT_A_OUTPUT_LATCH: impl_mask = `IOD_MASK_FULL;
            `IOD_ADDR_PORT_C_INPUT_LEVELS, `IOD_ADDR_PORT_C_DIRECTION, `IOD_ADDR_PORT_C_OUTPUT_LATCH: impl_mask = `IOD_MASK_PORT_C_OUTPUT_LATCH;
            `IOD_ADDR_PORT_D_INPUT_LEVELS, `IOD_ADDR_PORT_D_DIRECTION, `IOD_ADDR_PORT_D_OUTPUT_LATCH: impl_mask = `IOD_MASK_FULL;
            `IOD_ADDR_PORT_E_INPUT_LEVELS, `IOD_ADDR_PORT_E_DIRECTION, `IOD_ADDR_PORT_E_OUTPUT_LATCH: impl_mask = `IOD_MASK_FULL;
            `IOD_ADDR_TFLG0, `IOD_ADDR_TFLG1:                 impl_mask = `IOD_MASK_TFLG;
            `IOD_ADDR_PCFLG, `IOD_ADDR_EIFLG:                 impl_mask = `IOD_MASK_NIB;
            `IOD_ADDR_EIMASK, `IOD_ADDR_T0CB, `IOD_ADDR_SLEEP: impl_mask = `IOD_MASK_NIB;
            `IOD_ADDR_PRESC:                                  impl_mask = `IOD_MASK_PRESC;
            `IOD_ADDR_T0CA:                                   impl_mask = `IOD_MASK_T0CA;
            `IOD_ADDR_RSTC:                                   impl_mask = `IOD_MASK_RSTC;
            `IOD_ADDR_SCR0, `IOD_ADDR_SCR1, `IOD_ADDR_SCR2:   impl_mask = `IOD_MASK_FULL;
            `IOD_ADDR_T0CNT, `IOD_ADDR_T0CMP, `IOD_ADDR_DBGCH: impl_mask = `IOD_MASK_FULL;
            `IOD_ADDR_SPROG, `IOD_ADDR_STKL, `IOD_ADDR_STKH:  impl_mask = `IOD_MASK_FULL;
            `IOD_ADDR_CPUST:                                  impl_mask = `IOD_MASK_FULL;
            default:                                          impl_mask = `IOD_MASK_NONE;
        endcase
    endfunction

    function automatic logic is_w1c(input logic [5:0] a);
        case (a)
            `IOD_ADDR_TFLG0, `IOD_ADDR_TFLG1, `IOD_ADDR_PCFLG, `IOD_ADDR_EIFLG: is_w1c = 1'b1;
            default: is_w1c = 1'b0;
        endcase
    endfunction

    function automatic logic is_ro(input logic [5:0] a);
        case (a)
            `IOD_ADDR_PORT_A_INPUT_LEVELS, `IOD_ADDR_PORT_C_INPUT_LEVELS, `IOD_ADDR_PORT_D_INPUT_LEVELS, `IOD_ADDR_PORT_E_INPUT_LEVELS: is_ro = 1'b1;
            default: is_ro = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic             is_bit_op;
    logic             is_port_op;
    logic             is_data_op;
    logic             hit;
    logic             ext_hit;
    logic [5:0]       io_addr;
    logic [7:0]       data_sub;
    logic [7:0]       cur;
    logic [7:0]       bit_sel;
    logic             wr_en;
    logic [7:0]       wr_val;
    logic [63:0][7:0] evt;

    assign is_bit_op  = (req_kind_i == REQ_BIT_SET) || (req_kind_i == REQ_BIT_CLEAR)
                     || (req_kind_i == REQ_SKIP_SET) || (req_kind_i == REQ_SKIP_CLEAR);
    assign is_port_op = (req_kind_i == REQ_PORT_IN) || (req_kind_i == REQ_PORT_OUT);
    assign is_data_op = (req_kind_i == REQ_DATA_LOAD) || (req_kind_i == REQ_DATA_STORE);
    assign data_sub   = addr_i - `IOD_DATA_OFFSET;
    assign bit_sel    = 8'h01 << bit_i;

    always_comb begin
        hit     = 1'b0;
        ext_hit = 1'b0;
        io_addr = addr_i[5:0];
        if (is_bit_op) begin
            hit = (addr_i <= `IOD_BIT_TOP);
        end else if (is_port_op) begin
            hit = (addr_i <= `IOD_PORT_TOP);
        end else if (is_data_op) begin
            if (addr_i >= `IOD_EXT_BASE) begin
                ext_hit = 1'b1;
            end else if (addr_i >= `IOD_DATA_OFFSET) begin
                hit     = 1'b1;
                io_addr = data_sub[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        case (io_addr)
            `IOD_ADDR_PORT_A_INPUT_LEVELS: cur = port_a_pins_i;
            `IOD_ADDR_PORT_C_INPUT_LEVELS: cur = port_c_pins_i & `IOD_MASK_PORT_C_OUTPUT_LATCH;
            `IOD_ADDR_PORT_D_INPUT_LEVELS: cur = port_d_pins_i;
            `IOD_ADDR_PORT_E_INPUT_LEVELS: cur = port_e_pins_i;
            default:        cur = state_q.regs[io_addr] & impl_mask(io_addr);
        endcase
    end

    // ----------------------------------------------------------------
    // write value, bit ops as read-modify-write
    // ----------------------------------------------------------------
    always_comb begin
        wr_en  = 1'b0;
        wr_val = wdata_i;
        if (req_valid_i && hit) begin
            case (req_kind_i)
                REQ_PORT_OUT, REQ_DATA_STORE: begin
                    wr_en = 1'b1;
                end
                REQ_BIT_SET: begin
                    wr_en  = 1'b1;
                    wr_val = cur | bit_sel;
                end
                REQ_BIT_CLEAR: begin
                    wr_en  = 1'b1;
                    wr_val = cur & ~bit_sel;
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // hardware flag events
    // ----------------------------------------------------------------
    always_comb begin
        evt = '0;
        evt[`IOD_ADDR_TFLG0] = {6'h00, timer0_flag_set_i};
        evt[`IOD_ADDR_TFLG1] = {6'h00, timer1_flag_set_i};
        evt[`IOD_ADDR_PCFLG] = {4'h0, pin_change_flag_set_i};
        evt[`IOD_ADDR_EIFLG] = {4'h0, ext_irq_flag_set_i};
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d           = state_q;
        state_d.ack       = req_valid_i;
        state_d.rdata     = 8'h00;
        state_d.skip      = 1'b0;
        state_d.refused   = req_valid_i && !hit && !ext_hit;
        state_d.ext_valid = req_valid_i && ext_hit;
        state_d.ext_write = req_valid_i && ext_hit && (req_kind_i == REQ_DATA_STORE);
        if (req_valid_i && ext_hit) begin
            state_d.ext_addr  = addr_i;
            state_d.ext_wdata = wdata_i;
        end
        if (req_valid_i && hit) begin
            if ((req_kind_i == REQ_PORT_IN) || (req_kind_i == REQ_DATA_LOAD)) begin
                state_d.rdata = cur;
            end
            if (req_kind_i == REQ_SKIP_SET) begin
                state_d.skip = cur[bit_i];
            end
            if (req_kind_i == REQ_SKIP_CLEAR) begin
                state_d.skip = !cur[bit_i];
            end
        end
        for (int i = 0; i < 64; i++) begin
            if (wr_en && (io_addr == 6'(i)) && !is_ro(6'(i))) begin
                if (is_w1c(6'(i))) begin
                    state_d.regs[i] = state_q.regs[i] & ~wr_val;
                end else begin
                    state_d.regs[i] = wr_val & impl_mask(6'(i));
                end
            end
            state_d.regs[i] = (state_d.regs[i] | evt[i]) & impl_mask(6'(i));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= '0;
            for (int i = 0; i < 64; i++) begin
                state_q.regs[i] <= `IOD_RESET_VALUE;
            end
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign ack_o        = state_q.ack;
    assign rdata_o      = state_q.rdata;
    assign skip_o       = state_q.skip;
    assign refused_o    = state_q.refused;
    assign ext_valid_o  = state_q.ext_valid;
    assign ext_write_o  = state_q.ext_write;
    assign ext_addr_o   = state_q.ext_addr;
    assign ext_wdata_o  = state_q.ext_wdata;
    assign port_a_dir_o = state_q.regs[`IOD_ADDR_PORT_A_DIRECTION];
    assign port_a_out_o = state_q.regs[`IOD_ADDR_PORT_A_OUTPUT_LATCH];
    assign port_c_dir_o = state_q.regs[`IOD_ADDR_PORT_C_DIRECTION];
    assign port_c_out_o = state_q.regs[`IOD_ADDR_PORT_C_OUTPUT_LATCH];
    assign port_d_dir_o = state_q.regs[`IOD_ADDR_PORT_D_DIRECTION];
    assign port_d_out_o = state_q.regs[`IOD_ADDR_PORT_D_OUTPUT_LATCH];
    assign port_e_dir_o = state_q.regs[`IOD_ADDR_PORT_E_DIRECTION];
    assign port_e_out_o = state_q.regs[`IOD_ADDR_PORT_E_OUTPUT_LATCH];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_bit_far;
        req_valid_i && is_bit_op && (addr_i > `IOD_BIT_TOP);
    endsequence

    sequence s_port_far;
        req_valid_i && is_port_op && (addr_i > `IOD_PORT_TOP);
    endsequence

    sequence s_eiflg_clear;
        req_valid_i && (req_kind_i == REQ_PORT_OUT) && (addr_i[5:0] == `IOD_ADDR_EIFLG)
            && (addr_i <= `IOD_PORT_TOP) && wdata_i[0] && !ext_irq_flag_set_i[0];
    endsequence

    sequence s_rmw_other_bit;
        req_valid_i && (req_kind_i == REQ_BIT_SET) && (addr_i == 8'h1C) && (bit_i == 3'h1)
            && state_q.regs[`IOD_ADDR_EIFLG][0] && !ext_irq_flag_set_i[0];
    endsequence

    sequence s_scratch_store;
        req_valid_i && (req_kind_i == REQ_DATA_STORE) && (addr_i == 8'h3E);
    endsequence

    AST_BIT_RANGE: assert property (s_bit_far |=> ack_o && refused_o && !skip_o)
        else $error("bit op above low range was not refused");

    AST_SKIP_VALUE: assert property (req_valid_i && (req_kind_i == REQ_SKIP_SET)
        && (addr_i <= `IOD_BIT_TOP) |=> skip_o == $past(cur[bit_i]))
        else $error("skip answer does not match tested bit");

    AST_SKIP_CLEAR: assert property (req_valid_i && (req_kind_i == REQ_SKIP_CLEAR)
        && (addr_i <= `IOD_BIT_TOP) |=> skip_o == !$past(cur[bit_i]))
        else $error("skip answer does not match cleared bit");

    AST_W1C_CLEAR: assert property (s_eiflg_clear
        |=> !state_q.regs[`IOD_ADDR_EIFLG][0])
        else $error("written one did not clear flag");

    AST_EVENT_WINS: assert property (ext_irq_flag_set_i[2]
        |=> state_q.regs[`IOD_ADDR_EIFLG][2])
        else $error("flag event lost");

    AST_RMW_CLEARS: assert property (s_rmw_other_bit
        |=> !state_q.regs[`IOD_ADDR_EIFLG][0] && !refused_o)
        else $error("bit set did not clear a flag read as set");

    AST_PORT_RANGE: assert property (s_port_far
        |=> ack_o && refused_o && (rdata_o == 8'h00))
        else $error("port op beyond 64 locations was not refused");

    AST_DATA_OFFSET: assert property (s_scratch_store
        |=> state_q.regs[`IOD_ADDR_SCR0] == $past(wdata_i))
        else $error("data-space store missed offset register");

    AST_LOW_DATA: assert property (req_valid_i && is_data_op
        && (addr_i < `IOD_DATA_OFFSET) |=> refused_o && !ext_valid_o)
        else $error("data op below i/o window was not refused");

    AST_EXT_ONLY_LS: assert property (req_valid_i && (addr_i >= `IOD_EXT_BASE)
        |=> (ext_valid_o == $past(is_data_op)) && (refused_o == !$past(is_data_op)))
        else $error("extended range reached by wrong instruction kind");

    AST_EXT_STORE: assert property (req_valid_i && (req_kind_i == REQ_DATA_STORE)
        && (addr_i >= `IOD_EXT_BASE) |=> ext_write_o && (ext_wdata_o == $past(wdata_i)))
        else $error("extended store not passed on");

    AST_RESERVED_BITS: assert property ((port_c_dir_o[7:6] == 2'b00)
        && (port_c_out_o[7:6] == 2'b00)
        && (state_q.regs[`IOD_ADDR_TFLG0][7:2] == 6'h00))
        else $error("reserved bit holds a one");

    AST_RO_INPUT: assert property (req_valid_i && (req_kind_i == REQ_PORT_IN)
        && (addr_i == 8'h06) |=> rdata_o[7:6] == 2'b00)
        else $error("reserved input level bit read as one");

endmodule

// File: iod_core_model.sv
// behavioural model of the processor core issuing i/o and load/store requests
`timescale 1ns/1ns
module iod_core_model (
    input  wire logic                  clk_sys_i,
    output logic                       req_valid_o,
    output iod_pkg::req_kind_type      req_kind_o,
    output logic [7:0]                 addr_o,
    output logic [2:0]                 bit_o,
    output logic [7:0]                 wdata_o,
    input  wire logic                  ack_i,
    output logic                       timed_out_o
);
    import iod_pkg::*;

    initial begin
        req_valid_o = 1'b0;
        req_kind_o  = REQ_PORT_IN;
        addr_o      = 8'h00;
        bit_o       = 3'h0;
        wdata_o     = 8'h00;
        timed_out_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // one request, held for the taking edge, then wait for the answer
    // ----------------------------------------------------------------
    task automatic xfer(input req_kind_type kind, input logic [7:0] addr,
                        input logic [2:0] sel, input logic [7:0] data);
        int n;
        @(negedge clk_sys_i);
        req_valid_o = 1'b1;
        req_kind_o  = kind;
        addr_o      = addr;
        bit_o       = sel;
        wdata_o     = data;
        @(negedge clk_sys_i);
        req_valid_o = 1'b0;
        // released lines do not keep the last value
        addr_o      = ~addr_o;
        wdata_o     = ~wdata_o;
        bit_o       = ~bit_o;
        n = 0;
        while (ack_i !== 1'b1 && n < 4) begin
            @(negedge clk_sys_i);
            n++;
        end
        timed_out_o = (n >= 4);
    endtask
endmodule

// File: tb_io_space_access_decoder.sv
// self-checking bench of the i/o space decoder
`timescale 1ns/1ns
module tb_io_space_access_decoder;
    import iod_pkg::*;
    logic                  clk_sys_i;
    logic                  rst_i;
    logic                  req_valid;
    req_kind_type          req_kind;
    logic [7:0]            addr;
    logic [2:0]            sel;
    logic [7:0]            wdata;
    logic [7:0]            pins_a, pins_c, pins_d, pins_e;
    logic [1:0]            tflg0, tflg1;
    logic [3:0]            pcflg, eiflg;
    logic                  ack, skip, refused, ext_valid, ext_write, timed_out;
    logic [7:0]            rdata, ext_addr, ext_wdata;
    logic [7:0]            a_dir, a_out, c_dir, c_out, d_dir, d_out, e_dir, e_out;
    int                    errors;
    int                    n_checks;
    // mapped read/write registers and their implemented bits
    logic [7:0] rw_addr [22] = '{8'h01, 8'h02, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E,
        8'h1D, 8'h1E, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h33, 8'h34,
        8'h3D, 8'h3E, 8'h3F};
    logic [7:0] rw_mask [22] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h0F, 8'hFF, 8'h83, 8'hC3, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h1F,
        8'hFF, 8'hFF, 8'hFF};
    logic [7:0] fl_addr [4] = '{8'h15, 8'h16, 8'h1B, 8'h1C};
    logic [7:0] fl_mask [4] = '{8'h03, 8'h03, 8'h0F, 8'h0F};

    io_space_access_decoder io_space_access_decoder_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_kind_i(req_kind),
        .addr_i(addr), .bit_i(sel), .wdata_i(wdata), .port_a_pins_i(pins_a),
        .port_c_pins_i(pins_c), .port_d_pins_i(pins_d), .port_e_pins_i(pins_e),
        .timer0_flag_set_i(tflg0), .timer1_flag_set_i(tflg1), .pin_change_flag_set_i(pcflg),
        .ext_irq_flag_set_i(eiflg), .ack_o(ack), .rdata_o(rdata), .skip_o(skip),
        .refused_o(refused), .ext_valid_o(ext_valid), .ext_write_o(ext_write),
        .ext_addr_o(ext_addr), .ext_wdata_o(ext_wdata), .port_a_dir_o(a_dir),
        .port_a_out_o(a_out), .port_c_dir_o(c_dir), .port_c_out_o(c_out),
        .port_d_dir_o(d_dir), .port_d_out_o(d_out), .port_e_dir_o(e_dir),
        .port_e_out_o(e_out));

    iod_core_model iod_core_model_inst (
        .clk_sys_i(clk_sys_i), .req_valid_o(req_valid), .req_kind_o(req_kind),
        .addr_o(addr), .bit_o(sel), .wdata_o(wdata), .ack_i(ack), .timed_out_o(timed_out));

    always #10 clk_sys_i = ~clk_sys_i;

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic op(input req_kind_type k, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d, input logic exp_ref);
        iod_core_model_inst.xfer(k, a, b, d);
        if (timed_out) begin
            errors++;
            $display("Error at %0t: request never answered", $time);
            test_done();
        end
        check({7'h00, refused}, {7'h00, exp_ref});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        op(REQ_PORT_IN, a, 3'h0, 8'h00, 1'b0);
        check(rdata, exp);
    endtask

    task automatic pulse_flags();
        @(negedge clk_sys_i);
        tflg0 = 2'b11;
        tflg1 = 2'b11;
        pcflg = 4'hF;
        eiflg = 4'hF;
        @(negedge clk_sys_i);
        tflg0 = 2'b00;
        tflg1 = 2'b00;
        pcflg = 4'h0;
        eiflg = 4'h0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        rst_i = 1'b1;
        {pins_a, pins_c, pins_d, pins_e} = 32'h0000_0000;
        {tflg0, tflg1, pcflg, eiflg} = 12'h000;
        errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        for (int i = 0; i < 22; i++) begin
            rd(rw_addr[i], 8'h00);
            op(REQ_PORT_OUT, rw_addr[i], 3'h0, 8'hFF, 1'b0);
            rd(rw_addr[i], rw_mask[i]);
            op(REQ_DATA_STORE, rw_addr[i] + 8'h20, 3'h0, 8'h5A & rw_mask[i], 1'b0);
            op(REQ_DATA_LOAD, rw_addr[i] + 8'h20, 3'h0, 8'h00, 1'b0);
            check(rdata, 8'h5A & rw_mask[i]);
        end
        check(a_dir, 8'h5A);
        check(c_out, 8'h1A);
        check(d_dir, 8'h5A);
        check(d_out, 8'h5A);
        check(e_dir, 8'h5A);
        check(e_out, 8'h5A);
        check(c_dir, 8'h1A);
        check(a_out, 8'h5A);
        $display("test register map done");
        @(negedge clk_sys_i);
        {pins_a, pins_c, pins_d, pins_e} = 32'hA5FF_3C81;
        op(REQ_PORT_OUT, 8'h00, 3'h0, 8'h00, 1'b0);
        rd(8'h00, 8'hA5);
        rd(8'h06, 8'h3F);
        rd(8'h09, 8'h3C);
        rd(8'h0C, 8'h81);
        $display("test input levels done");
        pulse_flags();
        for (int i = 0; i < 4; i++) begin
            rd(fl_addr[i], fl_mask[i]);
            op(REQ_PORT_OUT, fl_addr[i], 3'h0, 8'h00, 1'b0);
            rd(fl_addr[i], fl_mask[i]);
            op(REQ_PORT_OUT, fl_addr[i], 3'h0, 8'h01, 1'b0);
            rd(fl_addr[i], fl_mask[i] & 8'hFE);
        end
        pulse_flags();
        op(REQ_BIT_CLEAR, 8'h1C, 3'h3, 8'h00, 1'b0);
        rd(8'h1C, 8'h08);
        op(REQ_BIT_SET, 8'h16, 3'h0, 8'h00, 1'b0);
        rd(8'h16, 8'h00);
        pulse_flags();
        op(REQ_BIT_SET, 8'h1C, 3'h1, 8'h00, 1'b0);
        rd(8'h1C, 8'h00);
        eiflg = 4'h4;
        op(REQ_PORT_OUT, 8'h1C, 3'h0, 8'h04, 1'b0);
        eiflg = 4'h0;
        rd(8'h1C, 8'h04);
        $display("test status flags done");
        op(REQ_BIT_SET, 8'h02, 3'h0, 8'h00, 1'b0);
        op(REQ_BIT_CLEAR, 8'h02, 3'h6, 8'h00, 1'b0);
        check(a_out, 8'h1B);
        op(REQ_BIT_SET, 8'h2A, 3'h0, 8'h00, 1'b1);
        op(REQ_BIT_CLEAR, 8'h2A, 3'h1, 8'h00, 1'b1);
        rd(8'h2A, 8'h5A);
        for (int b = 0; b < 8; b++) begin
            op(REQ_SKIP_SET, 8'h02, b[2:0], 8'h00, 1'b0);
            check({7'h00, skip}, (8'h1B >> b) & 8'h01);
            op(REQ_SKIP_CLEAR, 8'h02, b[2:0], 8'h00, 1'b0);
            check({7'h00, skip}, ~(8'h1B >> b) & 8'h01);
        end
        op(REQ_SKIP_SET, 8'h2A, 3'h1, 8'h00, 1'b1);
        check({7'h00, skip}, 8'h00);
        $display("test bit access done");
        op(REQ_PORT_IN, 8'h40, 3'h0, 8'h00, 1'b1);
        op(REQ_PORT_OUT, 8'h40, 3'h0, 8'h77, 1'b1);
        op(REQ_DATA_LOAD, 8'h60, 3'h0, 8'h00, 1'b0);
        check({6'h00, ext_valid, ext_write}, 8'h02);
        check(ext_addr, 8'h60);
        check(rdata, 8'h00);
        op(REQ_DATA_STORE, 8'hFF, 3'h0, 8'hC3, 1'b0);
        check({6'h00, ext_valid, ext_write}, 8'h03);
        check(ext_addr, 8'hFF);
        check(ext_wdata, 8'hC3);
        op(REQ_PORT_IN, 8'h60, 3'h0, 8'h00, 1'b1);
        check({7'h00, ext_valid}, 8'h00);
        op(REQ_BIT_SET, 8'h60, 3'h0, 8'h00, 1'b1);
        op(REQ_SKIP_CLEAR, 8'h60, 3'h0, 8'h00, 1'b1);
        op(REQ_DATA_LOAD, 8'h10, 3'h0, 8'h00, 1'b1);
        $display("test address ranges done");
        test_done();
    end
endmodule
